//--- general_purpose_port_block_tb.sv
// Self-checking bench for the port block top.
// Assumes the board model and the design files compile first.
`timescale 1ns/1ps
`include "gpp_defs.svh"
module general_purpose_port_block_tb;
  import gpp_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        wdt_rst = 1'b0;
  logic        halt = 1'b0;
  gpp_addr_t   acc_addr = 7'h00;
  logic        acc_wr = 1'b0;
  logic        acc_rd = 1'b0;
  gpp_nib_t    acc_wdata = 4'h0;
  gpp_nib_t    acc_rdata;
  logic [47:0] bd_pin_i, bd_pin_o, bd_pin_oe;
  logic [47:0] ext_val = {12{4'h5}};
  logic [47:0] ext_en = {48{1'b1}};
  logic [47:0] ext_force = 48'h0;
  logic [11:0] in_pin_i;
  logic [11:0] in_val = 12'h9c3;
  logic [11:0] in_en = 12'hfff;
  gpp_nib_t    pd_on, od_pin_o, od_pin_oe, od_lvl, v;
  int          fail_count = 0;
  int          check_count = 0;

  always #2.5 mclk = ~mclk;

  gpp_top u_gpp_top (.mclk(mclk), .rst_b(rst_b), .wdt_rst(wdt_rst),
    .halt(halt), .acc_addr(acc_addr), .acc_wr(acc_wr), .acc_rd(acc_rd),
    .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .bd_pin_i(bd_pin_i),
    .bd_pin_o(bd_pin_o), .bd_pin_oe(bd_pin_oe), .in_pin_i(in_pin_i),
    .pd_on(pd_on), .od_pin_o(od_pin_o), .od_pin_oe(od_pin_oe));
  gpp_board u_gpp_board (.mclk(mclk), .bd_pin_o(bd_pin_o),
    .bd_pin_oe(bd_pin_oe), .ext_val(ext_val), .ext_en(ext_en),
    .ext_force(ext_force), .pd_on(pd_on), .in_val(in_val), .in_en(in_en),
    .od_pin_oe(od_pin_oe), .bd_pin_i(bd_pin_i), .in_pin_i(in_pin_i),
    .od_lvl(od_lvl));

  task automatic give_verdict;
    if (fail_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [47:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // One-cycle strobe, outputs looked at once the taking edge has landed
  task automatic wr(input gpp_addr_t a, input gpp_nib_t d);
    @(posedge mclk);
    acc_addr <= a;
    acc_wdata <= d;
    acc_wr <= 1'b1;
    @(posedge mclk);
    acc_wr <= 1'b0;
    #1;
  endtask
  task automatic rchk(input gpp_addr_t a, input gpp_nib_t e);
    @(posedge mclk);
    acc_addr <= a;
    acc_rd <= 1'b1;
    @(posedge mclk);
    acc_rd <= 1'b0;
    #1;
    chk("rdata", {44'h0, acc_rdata}, {44'h0, e});
  endtask
  // Pin changes need the synchroniser's four edges plus margin
  task automatic settle;
    repeat (5) @(posedge mclk);
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge mclk);
    fail_count++;
    give_verdict;
  end

  initial begin
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    #1;
    chk("oe", bd_pin_oe, 48'h0);
    chk("o", bd_pin_o, 48'h0);
    chk("pd", {44'h0, pd_on}, 48'hf);
    chk("od", {44'h0, od_pin_oe}, 48'hf);
    rchk(`GPP_A_DIR_TOP, 4'h0);
    // Port 0: low pins out, top pins in, then forced top pin
    wr(`GPP_A_DIR_TOP, 4'h3);
    wr(`GPP_A_DAT_BASE, 4'ha);
    chk("oe0", bd_pin_oe, 48'h3);
    chk("o0", {44'h0, bd_pin_o[3:0]}, 48'ha);
    settle;
    rchk(`GPP_A_DAT_BASE, 4'h6);
    wr(`GPP_A_DIR_TOP, 4'hf);
    ext_force[2] <= 1'b1;
    settle;
    rchk(`GPP_A_DAT_BASE, 4'he);
    chk("rewr", {44'h0, bd_pin_o[3:0]}, 48'he);
    ext_force <= 48'h0;
    // Port 1: latch hidden in input mode, shown in output mode
    wr(7'h71, 4'hf);
    settle;
    rchk(7'h71, 4'h5);
    wr(7'h6e, 4'hf);
    rchk(7'h71, 4'hf);
    // Group ports switch a whole nibble
    wr(`GPP_A_GRP_DIR, 4'h2);
    chk("oeg", bd_pin_oe[47:32], 48'h00f0);
    rchk(`GPP_A_GRP_DIR, 4'h2);
    wr(7'h79, 4'h3);
    rchk(7'h79, 4'h3);
    rchk(7'h78, 4'h5);
    // Three-pin port keeps its absent bit at 0
    wr(7'h6b, 4'hf);
    rchk(7'h6b, 4'h7);
    chk("oe19", {47'h0, bd_pin_oe[19]}, 48'h0);
    // Input-only ports ignore writes
    rchk(`GPP_A_PD_IN, 4'h3);
    wr(`GPP_A_IN_ONE, 4'h0);
    rchk(`GPP_A_IN_ONE, 4'hc);
    rchk(`GPP_A_IN_TWO, 4'h9);
    wr(`GPP_A_PD_SEL, 4'h5);
    chk("pdsel", {44'h0, pd_on}, 48'ha);
    // Pins 1 and 3 left undriven fall to their connected pull-downs
    in_en <= 12'hff5;
    settle;
    rchk(`GPP_A_PD_IN, 4'h1);
    chk("pdlow", {44'h0, acc_rdata & 4'ha}, 48'h0);
    // Open-drain port
    wr(`GPP_A_OD_OUT, 4'h6);
    chk("odoe", {44'h0, od_pin_oe}, 48'h9);
    chk("odlv", {44'h0, od_lvl}, 48'h6);
    chk("odo", {44'h0, od_pin_o}, 48'h0);
    rchk(`GPP_A_OD_OUT, 4'h6);
    // Halt refuses access and keeps every latch
    @(posedge mclk);
    halt <= 1'b1;
    wr(`GPP_A_DAT_BASE, 4'h0);
    @(posedge mclk);
    halt <= 1'b0;
    #1;
    chk("halt", {44'h0, bd_pin_o[3:0]}, 48'he);
    // Idle time without a hard reset keeps state
    settle;
    chk("keep", {44'h0, pd_on}, 48'ha);
    // Watchdog reset clears as power-on does
    @(posedge mclk);
    wdt_rst <= 1'b1;
    @(posedge mclk);
    wdt_rst <= 1'b0;
    #1;
    chk("woe", bd_pin_oe, 48'h0);
    chk("wo", bd_pin_o, 48'h0);
    chk("wpd", {44'h0, pd_on}, 48'hf);
    chk("wod", {44'h0, od_pin_oe}, 48'hf);
    give_verdict;
  end
endmodule

//--- gpp_bidir_port.sv
// One four-pin two-way port: direction bits, output latch, read view.
// Assumes strobes arrive already decoded and gated by halt.
`timescale 1ns/1ps
`include "gpp_defs.svh"
module gpp_bidir_port
  import gpp_pkg::*;
#(
  parameter gpp_nib_t PMASK = `GPP_MASK_FULL,  // Pins that exist
  parameter gpp_nib_t LVLRD = `GPP_RST_NIB     // Pins read by level
) (
  input  wire logic mclk,       // System clock
  input  wire logic rst_b,      // Power-on reset, active low
  gpp_port_if.port  pp          // Control and status
);
  gpp_nib_t dir_r, lat_r, dir_nxt, lat_nxt;
  wire gpp_nib_t lvl_out = dir_r & LVLRD;   // Pins whose latch a read rewrites
  wire gpp_nib_t lat_sel = dir_r & ~LVLRD;  // Pins that read back the latch

  // Next state; a read never coincides with a write to the same port
  assign dir_nxt = pp.wr_dir ? (pp.wdata & PMASK) : dir_r;
  assign lat_nxt = pp.wr_dat ? (pp.wdata & PMASK) :
                   pp.rd_dat ? ((lat_r & ~lvl_out) |
                                (pp.pin & lvl_out)) :
                   lat_r;

  // Only power-on and watchdog resets clear; others leave state alone
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dir_r <= `GPP_RST_NIB;
      lat_r <= `GPP_RST_NIB;
    end else if (pp.wdt) begin
      dir_r <= `GPP_RST_NIB;
      lat_r <= `GPP_RST_NIB;
    end else begin
      dir_r <= dir_nxt;
      lat_r <= lat_nxt;
    end
  end

  // Output pins show the latch; input and level-read pins show the level
  assign pp.dir   = dir_r;
  assign pp.lat   = lat_r;
  assign pp.rview = ((lat_r & lat_sel) | (pp.pin & ~lat_sel))
                    & PMASK;
endmodule

//--- gpp_board.sv
// Board model on the far side of the port pins.
// Assumes one clock; floating lines toggle every cycle.
`timescale 1ns/1ps
module gpp_board (
  input  wire logic        mclk,       // System clock
  input  wire logic [47:0] bd_pin_o,   // Design drive values
  input  wire logic [47:0] bd_pin_oe,  // Design drive enables
  input  wire logic [47:0] ext_val,    // Board levels
  input  wire logic [47:0] ext_en,     // Board drives when design does not
  input  wire logic [47:0] ext_force,  // Board overpowers the design
  input  wire logic [3:0]  pd_on,      // Pull-down connects
  input  wire logic [11:0] in_val,     // Input-only levels
  input  wire logic [11:0] in_en,      // Input-only pins driven
  input  wire logic [3:0]  od_pin_oe,  // Open-drain pull-low
  output logic      [47:0] bd_pin_i,   // Two-way wire levels
  output logic      [11:0] in_pin_i,   // Input-only wire levels
  output logic      [3:0]  od_lvl      // Open-drain wire level
);
  logic flt = 1'b0;
  // Undriven lines must not settle to a stable guess
  always @(posedge mclk) flt <= ~flt;
  // Wire resolution: forced board, then design, then board, else float
  assign bd_pin_i = (ext_force & ext_val) | (~ext_force & ((bd_pin_oe &
    bd_pin_o) | (~bd_pin_oe & ((ext_en & ext_val) |
    (~ext_en & {48{flt}})))));
  // A connected pull-down wins on an undriven pin 0 to 3; pins 4 to 11 float
  assign in_pin_i = (in_en & in_val) |
    (~in_en & ~{8'h00, pd_on} & {12{flt}});
  assign od_lvl = ~od_pin_oe;  // External pull-up
endmodule

//--- gpp_defs.svh
// Offsets, field masks and reset values of the general-purpose port block.
// Assumes a 7-bit data-memory address from the CPU and 4-bit data words.
`ifndef GPP_DEFS_SVH
`define GPP_DEFS_SVH

// Bit-port direction registers descend from the first port's address
`define GPP_A_DIR_TOP   7'h6f
`define GPP_A_GRP_DIR   7'h67
`define GPP_A_PD_SEL    7'h66
// Port data registers: twelve two-way ports, then the fixed-role ports
`define GPP_A_DAT_BASE  7'h70
`define GPP_A_PD_IN     7'h7c
`define GPP_A_IN_ONE    7'h7d
`define GPP_A_IN_TWO    7'h7e
`define GPP_A_OD_OUT    7'h7f

`define GPP_N_BIT_PORTS 8
`define GPP_N_ALL_PORTS 12
`define GPP_MASK_FULL   4'hf
`define GPP_MASK_THREE  4'h7
`define GPP_LVL_READ    4'hc
`define GPP_RST_NIB     4'h0
`define GPP_SYNC_W      60

`endif

//--- gpp_pkg.sv
// Types shared by the general-purpose port block.
// Assumes nothing beyond the constants header.
package gpp_pkg;
  typedef logic [3:0] gpp_nib_t;
  typedef logic [6:0] gpp_addr_t;
endpackage

//--- gpp_port_if.sv
// Carrier between the port block top and one four-pin two-way port.
// Assumes a single clock; strobes are one-cycle pulses.
`timescale 1ns/1ps
interface gpp_port_if;
  import gpp_pkg::*;
  logic     wr_dir;   // Direction write strobe
  logic     wr_dat;   // Latch write strobe
  logic     rd_dat;   // Data register read strobe
  logic     wdt;      // Watchdog/stack reset pulse
  gpp_nib_t wdata;    // Write data
  gpp_nib_t pin;      // Filtered pin levels
  gpp_nib_t dir;      // Direction, 1 = output
  gpp_nib_t lat;      // Output latch
  gpp_nib_t rview;    // Value a read returns
  modport ctl  (output wr_dir, wr_dat, rd_dat, wdt, wdata, pin,
                input  dir, lat, rview);
  modport port (input  wr_dir, wr_dat, rd_dat, wdt, wdata, pin,
                output dir, lat, rview);
endinterface

//--- gpp_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous pin levels; output moves only when stages 2 and 3 agree.
`timescale 1ns/1ps
module gpp_sync #(
  parameter int W = 4
) (
  input  wire logic         mclk,   // System clock
  input  wire logic         rst_b,  // Async reset, active low
  input  wire logic [W-1:0] d,      // Raw pin levels
  output logic      [W-1:0] q       // Filtered levels
);
  logic [W-1:0] s1_r, s2_r, s3_r;

  // Stage one feeds stage two only, to keep metastability contained
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q    <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q    <= (s2_r & s3_r) | (q & (s2_r ^ s3_r));
    end
  end
endmodule

//--- gpp_top.sv
// General-purpose port block: twelve two-way ports, three input-only
// ports, one open-drain output port, all reached by CPU register access.
// Assumes CPU access strobes are synchronous to mclk and one cycle long.
// Functional notes
// - Per-pin direction on bit ports, per-port on groups
// - Input-mode pin has its driver off
// - Input read returns pin level, high reads 1
// - Write in input mode updates latch only
// - Output-mode pin drives its latch value
// - Output read returns latch, except first port's top two pins
// - First port read rewrites output top-pin latches
// - Power-on and watchdog reset: input mode, latches 0
// - Chip-enable reset and clock stop keep state
// - Halt keeps every setting and latch
// - Writes to input-only ports change nothing
// - Pull-down bit: 0 connects, 1 disconnects
// - Power-on and watchdog reset connect all pull-downs
// - Chip-enable reset and clock stop keep pull-downs
// - Open-drain port pulls low for 0, floats for 1
// - Open-drain port read returns its latch
// - Open-drain latch always driven, cleared by hard resets
`timescale 1ns/1ps
module gpp_top
  import gpp_pkg::*;
(
  input  wire logic        mclk,        // 200 MHz system clock
  input  wire logic        rst_b,       // Power-on reset, active low
  input  wire logic        wdt_rst,     // Watchdog/stack reset pulse
  input  wire logic        halt,        // Halt status level
  input  wire gpp_addr_t   acc_addr,    // Register address
  input  wire logic        acc_wr,      // Write strobe
  input  wire logic        acc_rd,      // Read strobe
  input  wire gpp_nib_t    acc_wdata,   // Write data
  output gpp_nib_t         acc_rdata,   // Read data, registered
  input  wire logic [47:0] bd_pin_i,    // Two-way pin levels
  output logic      [47:0] bd_pin_o,    // Two-way pin drive values
  output logic      [47:0] bd_pin_oe,   // Two-way pin enables
  input  wire logic [11:0] in_pin_i,    // Input-only pin levels
  output gpp_nib_t         pd_on,       // Pull-down connect, high = on
  output gpp_nib_t         od_pin_o,    // Open-drain drive value
  output gpp_nib_t         od_pin_oe    // Open-drain enable, high pulls low
);
  `include "gpp_defs.svh"

  logic [`GPP_SYNC_W-1:0] pin_f;
  gpp_nib_t acc_rdata_nxt, pd_r, od_r, grp_dir;
  gpp_nib_t rview [`GPP_N_ALL_PORTS];
  gpp_nib_t dirv  [`GPP_N_ALL_PORTS];

  // Halt freezes every setting and latch by refusing all CPU access
  wire logic ok_wr = acc_wr & ~halt;
  wire logic ok_rd = acc_rd & ~halt;

  // Chip-enable reset and clock stop have no path into this state: they
  // are simply not inputs, so retention is structural
  gpp_sync #(
    .W (`GPP_SYNC_W)
  ) u_sync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .d     ({in_pin_i, bd_pin_i}),
    .q     (pin_f)
  );

  gpp_port_if pif [`GPP_N_ALL_PORTS] ();

  // Twelve two-way ports; the last four take one direction bit each
  for (genvar k = 0; k < `GPP_N_ALL_PORTS; k++) begin : g_port
    localparam gpp_addr_t DAT_A = `GPP_A_DAT_BASE + 7'(k);
    localparam gpp_nib_t  PM = (k == 4 || k == 7) ? `GPP_MASK_THREE
                                                   : `GPP_MASK_FULL;
    localparam gpp_nib_t  LR = (k == 0) ? `GPP_LVL_READ : `GPP_RST_NIB;
    if (k < `GPP_N_BIT_PORTS) begin : g_bit
      localparam gpp_addr_t DIR_A = `GPP_A_DIR_TOP - 7'(k);
      assign pif[k].wr_dir = ok_wr && acc_addr == DIR_A;
      assign pif[k].wdata  = acc_wdata;
    end else begin : g_grp
      // A direction write goes to a whole group of four pins
      assign pif[k].wr_dir = ok_wr && acc_addr == `GPP_A_GRP_DIR;
      assign pif[k].wdata  = pif[k].wr_dir ? {4{acc_wdata[k-8]}}
                                           : acc_wdata;
    end
    assign pif[k].wr_dat = ok_wr && acc_addr == DAT_A;
    assign pif[k].rd_dat = ok_rd && acc_addr == DAT_A;
    assign pif[k].wdt    = wdt_rst;
    assign pif[k].pin    = pin_f[4*k +: 4];
    assign rview[k]      = pif[k].rview;
    assign dirv[k]       = pif[k].dir;
    assign bd_pin_o[4*k +: 4]  = pif[k].lat;
    assign bd_pin_oe[4*k +: 4] = pif[k].dir;

    gpp_bidir_port #(
      .PMASK (PM),
      .LVLRD (LR)
    ) u_port (
      .mclk  (mclk),
      .rst_b (rst_b),
      .pp    (pif[k])
    );
  end

  assign grp_dir = {dirv[11][0], dirv[10][0], dirv[9][0], dirv[8][0]};

  // Read selection; input-port writes reach no state
  always_comb begin
    acc_rdata_nxt = `GPP_RST_NIB;
    for (int k = 0; k < `GPP_N_BIT_PORTS; k++) begin
      if (acc_addr == `GPP_A_DIR_TOP - 7'(k)) begin
        acc_rdata_nxt = dirv[k];
      end
    end
    for (int k = 0; k < `GPP_N_ALL_PORTS; k++) begin
      if (acc_addr == `GPP_A_DAT_BASE + 7'(k)) begin
        acc_rdata_nxt = rview[k];
      end
    end
    unique case (acc_addr)
      `GPP_A_GRP_DIR: acc_rdata_nxt = grp_dir;
      `GPP_A_PD_SEL:  acc_rdata_nxt = pd_r;
      `GPP_A_PD_IN:   acc_rdata_nxt = pin_f[51:48];
      `GPP_A_IN_ONE:  acc_rdata_nxt = pin_f[55:52];
      `GPP_A_IN_TWO:  acc_rdata_nxt = pin_f[59:56];
      `GPP_A_OD_OUT:  acc_rdata_nxt = od_r;
      default:        acc_rdata_nxt = acc_rdata_nxt;
    endcase
  end

  // Read data holds until the next read, so a slow CPU can sample it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      acc_rdata <= `GPP_RST_NIB;
    end else if (ok_rd) begin
      acc_rdata <= acc_rdata_nxt;
    end
  end

  // Pull-down select and open-drain latch; only hard resets clear them
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pd_r <= `GPP_RST_NIB;
      od_r <= `GPP_RST_NIB;
    end else if (wdt_rst) begin
      pd_r <= `GPP_RST_NIB;
      od_r <= `GPP_RST_NIB;
    end else begin
      if (ok_wr && acc_addr == `GPP_A_PD_SEL) begin
        pd_r <= acc_wdata;
      end
      if (ok_wr && acc_addr == `GPP_A_OD_OUT) begin
        od_r <= acc_wdata;
      end
    end
  end

  // A 0 in the select connects the resistor
  assign pd_on     = ~pd_r;
  // Open drain: never drive high, enable pulls low for a latched 0
  assign od_pin_o  = `GPP_RST_NIB;
  assign od_pin_oe = ~od_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  wd_clears_all_a: assert property (
    wdt_rst |=> bd_pin_oe == 48'h0 && bd_pin_o == 48'h0 && od_r == 4'h0)
    else $error("watchdog reset left port state");
  wd_pd_conn_a: assert property (
    wdt_rst |=> pd_on == 4'hf) else $error("pull-downs not connected");
  od_drive_a: assert property (
    ok_wr && !wdt_rst && acc_addr == `GPP_A_OD_OUT
    |=> od_pin_oe == ~$past(acc_wdata) && od_pin_o == 4'h0)
    else $error("open-drain drive wrong");
  halt_hold_a: assert property (
    halt && !wdt_rst |=> $stable(bd_pin_oe) && $stable(bd_pin_o)
                         && $stable(pd_r) && $stable(acc_rdata))
    else $error("state moved during halt");
  in_write_nop_a: assert property (
    ok_wr && !wdt_rst && acc_addr inside {`GPP_A_PD_IN, `GPP_A_IN_ONE,
                                          `GPP_A_IN_TWO}
    |=> $stable(pd_r) && $stable(od_r) && $stable(bd_pin_o))
    else $error("input port write changed state");
  lvl_rewrite_a: assert property (
    ok_rd && !wdt_rst && acc_addr == `GPP_A_DAT_BASE && bd_pin_oe[3]
    |=> bd_pin_o[3] == $past(pin_f[3]))
    else $error("top pin latch not rewritten on read");
  dir_width_a: assert property (
    bd_pin_oe[19] == 1'b0 && bd_pin_oe[31] == 1'b0)
    else $error("missing pin direction bit set");
  od_read_a: assert property (
    ok_rd && acc_addr == `GPP_A_OD_OUT |=> acc_rdata == $past(od_r))
    else $error("open-drain read not latch");
  in_read_a: assert property (
    ok_rd && acc_addr == `GPP_A_IN_ONE |=> acc_rdata == $past(pin_f[55:52]))
    else $error("input port read wrong");
  dir_write_a: assert property (
    ok_wr && !wdt_rst && acc_addr == `GPP_A_DIR_TOP
    |=> bd_pin_oe[3:0] == $past(acc_wdata))
    else $error("bit port direction write lost");
  grp_dir_a: assert property (
    ok_wr && !wdt_rst && acc_addr == `GPP_A_GRP_DIR
    |=> bd_pin_oe[35:32] == {4{$past(acc_wdata[0])}}
        && bd_pin_oe[47:44] == {4{$past(acc_wdata[3])}})
    else $error("group direction write wrong");
  lat_write_a: assert property (
    ok_wr && !wdt_rst && acc_addr == `GPP_A_DAT_BASE + 7'h01
    |=> bd_pin_o[7:4] == $past(acc_wdata))
    else $error("output latch write lost");
  in_mode_read_a: assert property (
    ok_rd && acc_addr == `GPP_A_DAT_BASE + 7'h01 && bd_pin_oe[7:4] == 4'h0
    |=> acc_rdata == $past(pin_f[7:4]))
    else $error("input mode read not pin level");
  lat_read_a: assert property (
    ok_rd && acc_addr == `GPP_A_DAT_BASE + 7'h01 && bd_pin_oe[7:4] == 4'hf
    |=> acc_rdata == $past(bd_pin_o[7:4]))
    else $error("output mode read not latch");
  top_pin_read_a: assert property (
    ok_rd && acc_addr == `GPP_A_DAT_BASE
    |=> acc_rdata[3:2] == $past(pin_f[3:2]))
    else $error("top pins not read by level");
  pd_in_read_a: assert property (
    ok_rd && acc_addr == `GPP_A_PD_IN |=> acc_rdata == $past(pin_f[51:48]))
    else $error("pull-down port read wrong");
  pd_select_a: assert property (
    ok_wr && !wdt_rst && acc_addr == `GPP_A_PD_SEL
    |=> pd_on == ~$past(acc_wdata))
    else $error("pull-down select not applied");
  pd_keep_a: assert property (
    !wdt_rst && !(ok_wr && acc_addr == `GPP_A_PD_SEL) |=> $stable(pd_on))
    else $error("pull-down select moved");
  od_keep_a: assert property (
    !wdt_rst && !(ok_wr && acc_addr == `GPP_A_OD_OUT) |=> $stable(od_pin_oe))
    else $error("open-drain latch moved");
  od_low_only_a: assert property (
    od_pin_o == 4'h0) else $error("open-drain pin driven high");
  lat_width_a: assert property (
    bd_pin_o[19] == 1'b0 && bd_pin_o[31] == 1'b0)
    else $error("absent pin latch bit set");
endmodule
